// ---- src/atq_drive.sv ----
// Drive-side queued command port: APB task-file view, phase sequencer and line arbitration.
//
// What this block does
// - Queued mode reuses two lines for ownership.
// - Busy held until parameters are taken.
// - No interrupt ends the command phase.
// - Status read acks only in method two.
// - Win ownership arbitration before any data or completion phase.
// - Slave times out, then takes ownership.
// - Slave may light LED, releases first.
// - Data phase: flag, tag, then interrupt.
// - After ack: drop interrupt, busy, DRQ.
// - Block transfer with no interrupts.
// - Disconnect, host ack, clear flags, release.
// - Disconnect when out of data or space.
// - Interrupt ignores the drive select bit.
// - Completion: flag, error, tag, then interrupt.
// - Completion ack, disconnect, clear, release.
// - Two-bit error code in error top.
// - Issued tag and ack bit; returned tag.
// - Queued status register bit layout.
`timescale 1ns/1ns
`include "atq_map.svh"
module atq_drive
  import atq_pkg::*;
#(
  parameter bit DRIVE_ONE = 1'b0,
  parameter int SETTLE_CYC = (`ATQ_SETTLE_NS + `ATQ_CLK_NS - 1) / `ATQ_CLK_NS,
  parameter int TMO_BASE_CYC = (`ATQ_TMO_BASE_NS + `ATQ_CLK_NS - 1) / `ATQ_CLK_NS
) (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Ownership lines, open drain, active low on the wire.
  input wire logic drive_zero_owns_irq_in,
  output logic drive_zero_owns_irq_out,
  output logic drive_zero_owns_irq_oe,
  input wire logic drive_one_owns_irq_in,
  output logic drive_one_owns_irq_out,
  output logic drive_one_owns_irq_oe,
  // Host interrupt, active high.
  output logic host_interrupt_line,
  // Drive state for the status register.
  input wire logic drive_ready_flag,
  input wire logic index_flag,
  // Command hand-off to firmware.
  output logic cmd_valid,
  output logic [7:0] cmd_code,
  output logic [5:0] cmd_tag,
  input wire logic cmd_taken,
  // Phase requests from firmware.
  input wire logic ph_data_req,
  input wire logic ph_done_req,
  input wire logic [5:0] ph_tag,
  input wire logic ph_err,
  input wire logic [1:0] ph_error_code,
  input wire logic ph_busy_req,
  input wire logic ph_xfer_ready,
  input wire logic ph_xfer_stop,
  // Phase state to firmware.
  output logic ph_acked,
  output logic ph_idle
);

  if (SETTLE_CYC < 1 || TMO_BASE_CYC < 1) begin : g_bad_cfg
    $error("atq_drive counts must be at least one cycle");
  end

  // ****************************************
  // APB decode
  // ****************************************

  logic pready_q;
  logic [7:0] tag_q;
  logic [7:0] sel_q;
  logic [2:0] cfg_q;
  logic setup;
  logic acc;
  logic wr;
  logic rd;
  logic hit;
  logic selected;
  logic [7:0] sts_byte;
  logic [7:0] err_byte;
  logic [7:0] rd_mux;

  // Access completes at the edge where the registered ready is seen with penable.
  assign setup = psel && !penable;
  assign acc = psel && penable && pready_q;
  assign wr = acc && pwrite;
  assign rd = acc && !pwrite;
  assign hit = (paddr == `ATQ_ERR_OFS) || (paddr == `ATQ_TAG_OFS) || (paddr == `ATQ_SEL_OFS)
    || (paddr == `ATQ_STS_OFS) || (paddr == `ATQ_ALT_OFS) || (paddr == `ATQ_CFG_OFS);
  assign selected = (sel_q[`ATQ_SEL_DRV] == DRIVE_ONE);

  // Configuration fields that steer the sequencer.
  logic qen;
  logic method2;
  logic led_en;
  logic host_ack;
  logic [5:0] issued_tag;
  assign qen = cfg_q[`ATQ_CFG_QEN];
  assign method2 = cfg_q[`ATQ_CFG_M2];
  assign led_en = cfg_q[`ATQ_CFG_LED];
  assign host_ack = tag_q[`ATQ_TAG_ACK];
  assign issued_tag = tag_q[5:0];

  // ****************************************
  // Phase and command state
  // ****************************************

  atq_phase_t ph_q;
  logic is_done_q;
  logic data_ph_q;
  logic cmpl_q;
  logic disconnect_flag_q;
  logic drq_q;
  logic ph_busy_q;
  logic cmd_busy_q;
  logic err_q;
  logic [1:0] ecode_q;
  logic [5:0] rtag_q;
  logic [5:0] req_tag_q;
  logic req_err_q;
  logic [1:0] req_code_q;
  logic irq_q;

  assign sts_byte = {cmd_busy_q || ph_busy_q, drive_ready_flag, disconnect_flag_q, cmpl_q,
                     drq_q, data_ph_q, index_flag, err_q};
  assign err_byte = {ecode_q, rtag_q};

  // Read selection; unmapped addresses read zero and answer with pslverr.
  assign rd_mux = (paddr == `ATQ_ERR_OFS) ? err_byte :
                  (paddr == `ATQ_TAG_OFS) ? tag_q :
                  (paddr == `ATQ_SEL_OFS) ? sel_q :
                  ((paddr == `ATQ_STS_OFS) || (paddr == `ATQ_ALT_OFS)) ? sts_byte :
                  (paddr == `ATQ_CFG_OFS) ? {5'h00, cfg_q} : 8'h00;

  // Only a status read of the selected drive counts as an acknowledge, and only in method two.
  logic sts_rd;
  logic cmd_wr;
  // status read acks in method two
  assign sts_rd = rd && (paddr == `ATQ_STS_OFS) && selected && method2;
  assign cmd_wr = wr && (paddr == `ATQ_STS_OFS) && selected;

  // host acknowledge by bit or read
  logic irq_ack;
  logic disconnect_flag_ack;
  assign irq_ack = irq_q && (method2 ? sts_rd : host_ack);
  assign disconnect_flag_ack = method2 ? sts_rd : !host_ack;

  // APB answer flops: no wait state, data captured at the setup edge.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_q <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else
    begin
      pready_q <= setup;
      if (setup)
      begin
        prdata <= {24'h00_0000, rd_mux};
        pslverr <= !hit;
      end
    end
  end
  assign pready = pready_q;

  // Software-written registers; the tag register keeps the host acknowledge bit.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tag_q <= `ATQ_TAG_RST;
      sel_q <= `ATQ_SEL_RST;
      cfg_q <= `ATQ_CFG_RST;
    end
    else if (wr)
    begin
      if (paddr == `ATQ_TAG_OFS)
        tag_q <= {1'b0, pwdata[6:0]};
      if (paddr == `ATQ_SEL_OFS)
        sel_q <= pwdata[7:0];
      if (paddr == `ATQ_CFG_OFS)
        cfg_q <= pwdata[2:0];
    end
  end

  // Command phase. A new command write beats a same-cycle taken so nothing is lost.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cmd_busy_q <= 1'b0;
      cmd_valid <= 1'b0;
      cmd_code <= 8'h00;
      cmd_tag <= 6'h00;
    end
    else if (cmd_wr)
    begin
      cmd_busy_q <= 1'b1;
      cmd_valid <= 1'b1;
      cmd_code <= pwdata[7:0];
      cmd_tag <= issued_tag;
    end
    else if (cmd_taken)
    begin
      cmd_busy_q <= 1'b0;
      cmd_valid <= 1'b0;
    end
  end

  // ****************************************
  // Ownership arbitration
  // ****************************************

  logic arb_won;
  logic arb_idle;
  logic own_oe;
  logic led_oe;
  logic peer;
  logic [15:0] rnd;

  // lines used only in queued mode
  assign peer = DRIVE_ONE ? !drive_zero_owns_irq_in : !drive_one_owns_irq_in;

  atq_lfsr #(
    .WIDTH(16)
  ) u_lfsr (
    .clk(pclk),
    .rst_n(presetn),
    .value(rnd)
  );

  atq_arbiter #(
    .SETTLE(SETTLE_CYC),
    .TMO_BASE(TMO_BASE_CYC)
  ) u_arb (
    .clk(pclk),
    .rst_n(presetn),
    .req((ph_q == P_ARB) && qen),
    .rel(ph_q == P_REL),
    .is_slave(DRIVE_ONE),
    .led_en(led_en),
    .seed(rnd[7:0]),
    .peer(peer),
    .won(arb_won),
    .idle(arb_idle),
    .own_oe(own_oe),
    .led_oe(led_oe)
  );

  // Lines are pulled low when enabled; the slave may also pull the LED line while it owns.
  assign drive_zero_owns_irq_oe = DRIVE_ONE ? led_oe : own_oe;
  assign drive_one_owns_irq_oe = DRIVE_ONE ? own_oe : 1'b0;
  assign drive_zero_owns_irq_out = 1'b0;
  assign drive_one_owns_irq_out = 1'b0;

  // ****************************************
  // Data and completion phase sequencer
  // ****************************************

  // Firmware requests are taken only when idle in queued mode; completion wins a tie.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ph_q <= P_IDLE;
      is_done_q <= 1'b0;
      req_tag_q <= 6'h00;
      req_err_q <= 1'b0;
      req_code_q <= 2'h0;
      data_ph_q <= 1'b0;
      cmpl_q <= 1'b0;
      disconnect_flag_q <= 1'b0;
      drq_q <= 1'b0;
      ph_busy_q <= 1'b0;
      err_q <= 1'b0;
      ecode_q <= 2'h0;
      rtag_q <= 6'h00;
      irq_q <= 1'b0;
    end
    else
    begin
      unique case (ph_q)
        P_IDLE:
          if (qen && (ph_data_req || ph_done_req))
          begin
            ph_q <= P_ARB;
            is_done_q <= ph_done_req;
            req_tag_q <= ph_tag;
            req_err_q <= ph_err;
            req_code_q <= ph_error_code;
          end
        P_ARB:
          if (arb_won)
          begin
            ph_q <= P_IRQ;
            rtag_q <= req_tag_q;
            data_ph_q <= !is_done_q;
            cmpl_q <= is_done_q;
            err_q <= is_done_q && req_err_q;
            ecode_q <= req_code_q;
          end
        P_IRQ:
          if (irq_ack)
          begin
            irq_q <= 1'b0;
            ph_busy_q <= ph_busy_req;
            ph_q <= P_SETUP;
          end
          else
            irq_q <= 1'b1;
        P_SETUP:
          if (ph_xfer_stop || (is_done_q && !ph_busy_q))
          begin
            ph_busy_q <= 1'b0;
            disconnect_flag_q <= 1'b1;
            ph_q <= P_DISCONNECT_FLAG;
          end
          else if (ph_xfer_ready && !is_done_q)
          begin
            drq_q <= 1'b1;
            ph_busy_q <= 1'b0;
            ph_q <= P_XFER;
          end
        P_XFER:
          if (ph_xfer_stop)
          begin
            drq_q <= 1'b0;
            ph_busy_q <= 1'b0;
            disconnect_flag_q <= 1'b1;
            ph_q <= P_DISCONNECT_FLAG;
          end
        P_DISCONNECT_FLAG:
          if (disconnect_flag_ack)
          begin
            disconnect_flag_q <= 1'b0;
            data_ph_q <= 1'b0;
            cmpl_q <= 1'b0;
            err_q <= 1'b0;
            ph_q <= P_REL;
          end
        P_REL:
          if (arb_idle)
            ph_q <= P_IDLE;
      endcase
    end
  end

  // ****************************************
  // Firmware-facing status
  // ****************************************

  // Registered so firmware sees stable levels; they trail the sequencer by one cycle.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ph_acked <= 1'b0;
      ph_idle <= 1'b0;
    end
    else
    begin
      ph_acked <= (ph_q == P_SETUP) || (ph_q == P_XFER);
      ph_idle <= (ph_q == P_IDLE);
    end
  end

  assign host_interrupt_line = irq_q;

endmodule // atq_drive

// ---- src/atq_map.svh ----
// Register offsets, field positions, reset values and timing figures for the queued drive port.
`ifndef ATQ_MAP_SVH
`define ATQ_MAP_SVH

// ****************************************
// Register byte offsets on the APB side
// ****************************************
`define ATQ_ERR_OFS 8'h04
`define ATQ_TAG_OFS 8'h08
`define ATQ_SEL_OFS 8'h18
`define ATQ_STS_OFS 8'h1c
`define ATQ_ALT_OFS 8'h38
`define ATQ_CFG_OFS 8'h40

// ****************************************
// Status register bit positions
// ****************************************
`define ATQ_STS_BUSY 7
`define ATQ_STS_RDY 6
`define ATQ_STS_DISCONNECT_FLAG 5
`define ATQ_STS_COMPLETE_FLAG 4
`define ATQ_STS_DRQ 3
`define ATQ_STS_DATA_PHASE_FLAG 2
`define ATQ_STS_IDX 1
`define ATQ_STS_ERR 0

// ****************************************
// Other fields
// ****************************************
`define ATQ_TAG_ACK 6
`define ATQ_SEL_DRV 4
`define ATQ_CFG_QEN 0
`define ATQ_CFG_M2 1
`define ATQ_CFG_LED 2

// ****************************************
// Reset values
// ****************************************
`define ATQ_TAG_RST 8'h00
`define ATQ_SEL_RST 8'h00
`define ATQ_CFG_RST 3'h0

// ****************************************
// Timing, in nanoseconds
// ****************************************
`define ATQ_CLK_NS 10
`define ATQ_SETTLE_NS 40
`define ATQ_TMO_BASE_NS 2000

`endif

// ---- src/atq_pkg.sv ----
// Types shared by the queued drive port modules.
package atq_pkg;

  // Phase sequencer states.
  typedef enum logic [2:0] {P_IDLE, P_ARB, P_IRQ, P_SETUP, P_XFER, P_DISCONNECT_FLAG, P_REL} atq_phase_t;

  // Ownership arbiter states.
  typedef enum logic [2:0] {A_IDLE, A_WAIT, A_ASSERT, A_YIELD, A_PEER, A_WON, A_DROP} atq_arb_t;

endpackage

// ---- src/atq_lfsr.sv ----
// Free-running pseudo-random source for the arbitration time-out.
`timescale 1ns/1ns
module atq_lfsr #(
  parameter int WIDTH = 16
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Random value.
  output logic [WIDTH-1:0] value
);

  if (WIDTH != 16) begin : g_bad_width
    $error("atq_lfsr supports only a width of 16");
  end

  logic [WIDTH-1:0] lfsr_q;
  logic [WIDTH-1:0] lfsr_d;

  // Galois form; the all-ones seed keeps the register out of the stuck zero state.
  assign lfsr_d = lfsr_q[0] ? ((lfsr_q >> 1) ^ 16'hb400) : (lfsr_q >> 1);
  assign value = lfsr_q;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      lfsr_q <= 16'hffff;
    else
      lfsr_q <= lfsr_d;
  end

endmodule // atq_lfsr

// ---- src/atq_arbiter.sv ----
// Two-line ownership arbiter for the shared host interrupt line.
`timescale 1ns/1ns
module atq_arbiter
  import atq_pkg::*;
#(
  parameter int SETTLE = 4,
  parameter int TMO_BASE = 200
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Control from the drive: sequencer request and release, role, LED enable and seed.
  input wire logic req,
  input wire logic rel,
  input wire logic is_slave,
  input wire logic led_en,
  input wire logic [7:0] seed,
  // Peer ownership line, high while asserted.
  input wire logic peer,
  // Results.
  output logic won,
  output logic idle,
  output logic own_oe,
  output logic led_oe
);

  if (SETTLE < 1 || TMO_BASE < 1 || TMO_BASE + 255 > 65535) begin : g_bad_cfg
    $error("atq_arbiter counts out of range");
  end

  atq_arb_t st_q;
  atq_arb_t st_d;
  logic [15:0] cnt_q;
  logic [15:0] cnt_d;
  logic cnt_zero;

  assign cnt_zero = (cnt_q == 16'h0000);
  assign won = (st_q == A_WON);
  assign idle = (st_q == A_IDLE);

  // Next state of the arbitration loop.
  always_comb
  begin
    st_d = st_q;
    cnt_d = cnt_zero ? cnt_q : cnt_q - 16'h0001;
    unique case (st_q)
      A_IDLE:
        if (req)
          st_d = A_WAIT;
      A_WAIT:
        if (!req)
          st_d = A_IDLE;
        else if (!peer)
        begin
          st_d = A_ASSERT;
          cnt_d = 16'(SETTLE);
        end
      A_ASSERT:
        if (cnt_zero)
        begin
          if (!peer)
            st_d = A_WON;
          else if (is_slave)
          begin
            st_d = A_YIELD;
            cnt_d = 16'(TMO_BASE) + {8'h00, seed};
          end
          else
            st_d = A_WAIT;
        end
      A_YIELD:
        if (peer)
          st_d = A_PEER;
        else if (cnt_zero)
          st_d = A_WON;
      A_PEER:
        if (!peer)
          st_d = A_WAIT;
      A_WON:
        if (rel)
          st_d = A_DROP;
      A_DROP:
        st_d = A_IDLE;
    endcase
  end

  // State, counter and line enables; enables follow the next state so they come from flops.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_q <= A_IDLE;
      cnt_q <= 16'h0000;
      own_oe <= 1'b0;
      led_oe <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      own_oe <= (st_d == A_ASSERT) || (st_d == A_WON) || (st_d == A_DROP);
      // LED line dropped before own line
      led_oe <= (st_d == A_WON) && is_slave && led_en;
    end
  end

endmodule // atq_arbiter

// ---- tb/atq_drive_asserts.sv ----
// Checker for the queued drive port, bound to the top module.
`timescale 1ns/1ns
`include "atq_map.svh"
module atq_drive_chk (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB side.
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  // Lines and command hand-off.
  input wire logic drive_one_owns_irq_in,
  input wire logic drive_zero_owns_irq_oe,
  input wire logic drive_one_owns_irq_oe,
  input wire logic host_interrupt_line,
  input wire logic cmd_valid,
  input wire logic cmd_taken
);
  logic acc_w;
  logic rd_w;
  logic m2_q;
  logic m2_d;
  logic s1_q;
  logic s1_d;
  // Completed accesses; the method bit is mirrored since it picks the ack style.
  assign acc_w = psel & penable & pready;
  assign rd_w = acc_w & !pwrite & host_interrupt_line;
  assign m2_d = (acc_w & pwrite & paddr == `ATQ_CFG_OFS) ? pwdata[1] : m2_q;
  // Only a status read while this drive is selected may acknowledge.
  assign s1_d = (acc_w & pwrite & paddr == `ATQ_SEL_OFS) ? pwdata[`ATQ_SEL_DRV] : s1_q;
  // Method and select bit mirrors.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      m2_q <= 1'h0;
      s1_q <= 1'h0;
    end
    else
    begin
      m2_q <= m2_d;
      s1_q <= s1_d;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  own_line_a: assert property (!drive_one_owns_irq_oe)
    else $error("drive 0 pulled the drive 1 line");
  irq_own_a: assert property (host_interrupt_line |-> drive_zero_owns_irq_oe)
    else $error("interrupt without ownership");
  arb_free_a: assert property ($rose(drive_zero_owns_irq_oe) |-> $past(drive_one_owns_irq_in))
    else $error("ownership taken over a busy peer");
  irq_rise_a: assert property ($rose(host_interrupt_line) |->
    $past(drive_zero_owns_irq_oe, 2) && drive_one_owns_irq_in)
    else $error("interrupt raised before arbitration was won");
  cmd_quiet_a: assert property ($rose(cmd_valid) |-> !$rose(host_interrupt_line))
    else $error("interrupt at command write");
  cmd_start_a: assert property ($rose(cmd_valid) |->
    $past(acc_w && pwrite && paddr == `ATQ_STS_OFS))
    else $error("command seen without a command write");
  cmd_hold_a: assert property (cmd_valid && !cmd_taken |=> cmd_valid)
    else $error("command dropped before it was taken");
  ack_bit_a: assert property (!m2_q && acc_w && pwrite && paddr == `ATQ_TAG_OFS &&
    pwdata[6] && host_interrupt_line |-> ##[1:2] !host_interrupt_line)
    else $error("ack bit did not clear the interrupt");
  ack_read_a: assert property (m2_q && !s1_q && rd_w && paddr == `ATQ_STS_OFS |->
    ##[1:2] !host_interrupt_line)
    else $error("status read did not clear the interrupt");
  alt_keep_a: assert property (rd_w && paddr == `ATQ_ALT_OFS |=> host_interrupt_line[*2])
    else $error("alternate status read cleared the interrupt");
  read_keep_a: assert property (!m2_q && rd_w && paddr == `ATQ_STS_OFS |=>
    host_interrupt_line[*2])
    else $error("status read cleared the interrupt under the ack bit method");
  other_read_a: assert property (m2_q && s1_q && rd_w && paddr == `ATQ_STS_OFS |=>
    host_interrupt_line[*2])
    else $error("status read of the other drive cleared the interrupt");
  cover property ($rose(host_interrupt_line));
  cover property ($fell(drive_zero_owns_irq_oe));
  cover property ($rose(cmd_valid));
endmodule // atq_drive_chk
bind atq_drive atq_drive_chk i_atq_drive_chk (.pclk(pclk), .presetn(presetn), .paddr(paddr),
  .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pready(pready),
  .drive_one_owns_irq_in(drive_one_owns_irq_in), .drive_zero_owns_irq_oe(drive_zero_owns_irq_oe),
  .drive_one_owns_irq_oe(drive_one_owns_irq_oe), .host_interrupt_line(host_interrupt_line),
  .cmd_valid(cmd_valid), .cmd_taken(cmd_taken));

// ---- tb/atq_peer.sv ----
// Behavioural peer drive that contends for the host interrupt line.
`timescale 1ns/1ns
module atq_peer (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Contention request from the bench.
  input wire logic grab,
  // Drive 0 line level, low while asserted.
  input wire logic own_zero_line,
  // Pull-down enable on the drive 1 line.
  output logic own_one_oe
);
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      own_one_oe <= 1'h0;
    else if (!grab)
      own_one_oe <= 1'h0;
    else if (own_zero_line)
      own_one_oe <= 1'h1;
  end
endmodule // atq_peer

// ---- tb/testbench.sv ----
// Self-checking bench for the queued drive port.
`timescale 1ns/1ns
`include "atq_map.svh"
module testbench;
  logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, grab = 1'h0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, er, z_oe, o_oe, peer_oe, irq, cmd_valid, acked, idle, z_out, o_out;
  logic [7:0] cmd_code;
  logic [5:0] cmd_tag, ph_tag = 6'h00;
  logic [4:0] pl = 5'h00;
  logic ph_err = 1'h0, ph_busy_req = 1'h0;
  logic [1:0] ph_error_code = 2'h0;
  wire logic own_zero = !z_oe;
  wire logic own_one = !(o_oe | peer_oe);
  int num_errors = 0, comparisons = 0, cycles = 0;
  // Short settle and time-out counts keep the arbitration runs brief.
  atq_drive #(.DRIVE_ONE(1'b0), .SETTLE_CYC(1), .TMO_BASE_CYC(8)) i_atq_drive (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .drive_zero_owns_irq_in(own_zero), .drive_zero_owns_irq_out(z_out),
    .drive_zero_owns_irq_oe(z_oe),
    .drive_one_owns_irq_in(own_one), .drive_one_owns_irq_out(o_out),
    .drive_one_owns_irq_oe(o_oe),
    .host_interrupt_line(irq), .drive_ready_flag(1'h1), .index_flag(1'h0),
    .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_tag(cmd_tag), .cmd_taken(pl[4]),
    .ph_data_req(pl[0]), .ph_done_req(pl[1]), .ph_tag(ph_tag), .ph_err(ph_err),
    .ph_error_code(ph_error_code), .ph_busy_req(ph_busy_req), .ph_xfer_ready(pl[2]),
    .ph_xfer_stop(pl[3]), .ph_acked(acked), .ph_idle(idle));
  atq_peer i_atq_peer (.pclk(pclk), .presetn(presetn), .grab(grab), .own_zero_line(own_zero),
    .own_one_oe(peer_oe));
  // Free-running clock.
  always #5 pclk = ~pclk;
  // Hang guard.
  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      num_errors++;
      wrap_up;
    end
  end
  task automatic wrap_up;
    $display("comparisons %0d num_errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp)
    begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  // One APB transfer; holds the request until pready is sampled high.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do
      @(posedge pclk);
    while (pready !== 1'h1);
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string w);
    apb(1'h0, a, 32'h0);
    chk(w, e, rd);
  endtask
  task automatic pulse(input int b);
    @(posedge pclk);
    pl[b] <= 1'h1;
    @(posedge pclk);
    pl[b] <= 1'h0;
  endtask
  // Bounded waits on the interrupt and on the line release.
  task automatic wait_irq(input logic lvl);
    for (int n = 0; n < 80 && irq !== lvl; n++)
      @(posedge pclk);
    chk("interrupt", {31'h0, lvl}, {31'h0, irq});
  endtask
  task automatic wait_free;
    for (int n = 0; n < 10 && own_zero !== 1'h1; n++)
      @(posedge pclk);
    chk("line released", 32'h1, {31'h0, own_zero});
  endtask
  task automatic t_regs;
    rdc(`ATQ_CFG_OFS, 32'h0, "config reset");
    rdc(`ATQ_TAG_OFS, 32'h0, "tag reset");
    apb(1'h1, `ATQ_TAG_OFS, 32'hff);
    rdc(`ATQ_TAG_OFS, 32'h7f, "tag field");
    chk("mapped error", 32'h0, {31'h0, er});
    rdc(8'h7c, 32'h0, "unmapped data");
    chk("unmapped error", 32'h1, {31'h0, er});
    chk("idle and pins", 32'h4, {29'h0, idle, z_out, o_out});
  endtask
  task automatic t_cmd;
    apb(1'h1, `ATQ_TAG_OFS, 32'h15);
    apb(1'h1, `ATQ_SEL_OFS, 32'h0);
    rdc(`ATQ_ALT_OFS, 32'h40, "ready before command");
    apb(1'h1, `ATQ_STS_OFS, 32'hd0);
    rdc(`ATQ_ALT_OFS, 32'hc0, "busy after command");
    chk("command", 32'h55d0, {17'h0, cmd_valid, cmd_tag, cmd_code});
    chk("no interrupt", 32'h0, {31'h0, irq});
    pulse(4);
    rdc(`ATQ_ALT_OFS, 32'h40, "busy cleared");
    chk("command taken", 32'h0, {31'h0, cmd_valid});
    apb(1'h1, `ATQ_SEL_OFS, 32'h10);
    apb(1'h1, `ATQ_STS_OFS, 32'hd0);
    rdc(`ATQ_ALT_OFS, 32'h40, "other drive command");
  endtask
  // Data phase under the ack bit, with the other drive selected.
  task automatic t_data;
    apb(1'h1, `ATQ_CFG_OFS, 32'h1);
    ph_tag <= 6'h05;
    ph_busy_req <= 1'h1;
    pulse(0);
    wait_irq(1'h1);
    chk("not idle", 32'h0, {31'h0, idle});
    chk("owning", 32'h0, {31'h0, own_zero});
    rdc(`ATQ_ALT_OFS, 32'h44, "data phase status");
    rdc(`ATQ_ERR_OFS, 32'h05, "returned tag");
    rdc(`ATQ_STS_OFS, 32'h44, "status read");
    apb(1'h1, `ATQ_TAG_OFS, 32'h45);
    wait_irq(1'h0);
    rdc(`ATQ_ALT_OFS, 32'hc4, "setup busy");
    chk("acked", 32'h1, {31'h0, acked});
    // task file untouched until the disconnect ack.
    pulse(2);
    rdc(`ATQ_ALT_OFS, 32'h4c, "transfer ready");
    pulse(3);
    rdc(`ATQ_ALT_OFS, 32'h64, "disconnect");
    chk("quiet transfer", 32'h0, {31'h0, irq});
    apb(1'h1, `ATQ_TAG_OFS, 32'h05);
    rdc(`ATQ_ALT_OFS, 32'h40, "data phase closed");
    wait_free;
  endtask
  // Completion under status-read ack, optionally with the peer holding its line.
  task automatic t_done(input logic [1:0] code, input logic contend);
    apb(1'h1, `ATQ_SEL_OFS, 32'h0);
    apb(1'h1, `ATQ_CFG_OFS, 32'h3);
    grab <= contend;
    ph_tag <= 6'h29;
    ph_err <= 1'h1;
    ph_error_code <= code;
    ph_busy_req <= 1'h0;
    pulse(1);
    if (contend)
    begin
      repeat (30) @(posedge pclk);
      chk("held off", 32'h0, {31'h0, irq});
      grab <= 1'h0;
    end
    wait_irq(1'h1);
    rdc(`ATQ_ALT_OFS, 32'h51, "completion status");
    rdc(`ATQ_ERR_OFS, {24'h0, code, 6'h29}, "error code");
    // A status read with the other drive selected must not acknowledge.
    apb(1'h1, `ATQ_SEL_OFS, 32'h10);
    apb(1'h0, `ATQ_STS_OFS, 32'h0);
    apb(1'h1, `ATQ_SEL_OFS, 32'h0);
    chk("other drive read", 32'h1, {31'h0, irq});
    apb(1'h0, `ATQ_STS_OFS, 32'h0);
    wait_irq(1'h0);
    rdc(`ATQ_ALT_OFS, 32'h71, "completion disconnect");
    apb(1'h0, `ATQ_STS_OFS, 32'h0);
    rdc(`ATQ_ALT_OFS, 32'h40, "completion closed");
    wait_free;
  endtask
  // Main sequence.
  initial
  begin
    repeat (10) @(posedge pclk);
    presetn <= 1'h1;
    t_regs;
    t_cmd;
    t_data;
    for (int c = 0; c < 4; c++)
      t_done(c[1:0], c == 0);
    wrap_up;
  end
endmodule // testbench
